/* src/asfp_top.sv */
// Fault protection and reset control for a two-pair power stage
// How it works
// RULE1 - Any transistor overcurrent trip limits current instead of shutting down.
// RULE2 - A trip lasting the overload time sets that pair's latched shutdown.
// RULE3 - Limiting and overload latching act separately per pair.
// RULE4 - The trip-setting field selects the trip current from 10.8 A to 4.7 A.
// RULE5 - Warning flag goes low above the warning temperature, operation continues.
// RULE6 - Above shutdown temperature all outputs go high impedance, shutdown low.
// RULE7 - Thermal latch holds until both pair resets are asserted together.
// RULE8 - Power-on reset clears overload and holds outputs off until supplies good.
// RULE9 - Any supply undervoltage puts all outputs off and drives shutdown low.
// RULE10 - Undervoltage recovery is automatic once all supplies are good.
// RULE11 - A low pair reset turns off that pair only.
// RULE12 - In bridge-tied mode a low pair reset enables its weak pulldowns.
// RULE13 - Single-ended mode never enables pulldowns; controller pulses PWM low.
// RULE14 - Either pair reset low forces the shutdown flag high.
// RULE15 - A rising edge on either pair reset clears the overload latches.
// RULE16 - Both flags are active low; shutdown means any latched or supply fault.
// RULE17 - Controller waits the recovery time before resetting after overload.
// RULE18 - Warning returns high on its own when temperature drops.
// RULE19 - Comparator events arrive as synchronous digital inputs.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asfp_consts.svh"

module asfp_top (
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    clk_en_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [`ASFP_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic                    pair_one_reset_n_i,
  input  wire logic                    pair_two_reset_n_i,
  input  wire logic [7:0]              oc_trip_i,
  input  wire logic                    overtemp_warn_i,
  input  wire logic                    overtemp_shut_i,
  input  wire logic                    gate_drive_supply_uv_i,
  input  wire logic                    logic_supply_uv_i,
  input  wire logic                    supply_at_level_i,
  input  wire logic                    fault_shutdown_n_i,
  output logic                         fault_shutdown_n_o,
  output logic                         fault_shutdown_n_oe_o,
  input  wire logic                    overtemp_warning_n_i,
  output logic                         overtemp_warning_n_o,
  output logic                         overtemp_warning_n_oe_o,
  output logic                         pair_one_hiz_o,
  output logic                         pair_two_hiz_o,
  output logic      [1:0]              current_limit_o,
  output logic      [1:0]              pulldown_en_o,
  output logic      [7:0]              trip_level_o,
  output logic                         irq_o
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam logic [`ASFP_OL_CNT_W-1:0] OL_LAST =
    `ASFP_OL_CNT_W'(`ASFP_OL_CYCLES - 1);

  logic                          bridge_tied_mode_r;
  asfp_pkg::asfp_trip_set_t      overcurrent_trip_set_r;
  logic [`ASFP_EVT_W-1:0]        irq_stat_r;
  logic [`ASFP_EVT_W-1:0]        irq_mask_r;
  logic [`ASFP_EVT_W-1:0]        evt;
  asfp_pkg::asfp_pair_vec_t      reset_n;
  asfp_pkg::asfp_pair_vec_t      reset_prev_r;
  asfp_pkg::asfp_pair_vec_t      reset_rise;
  asfp_pkg::asfp_pair_vec_t      oc_pair;
  asfp_pkg::asfp_pair_vec_t      overload_latch_r;
  asfp_pkg::asfp_pair_vec_t      ol_set;
  logic [`ASFP_OL_CNT_W-1:0]     ol_cnt_r [2];
  logic                          overtemp_shutdown_latch_r;
  logic                          undervoltage_guard;
  logic                          por_done_r;
  logic                          uv_prev_r;
  logic                          warn_prev_r;
  asfp_pkg::asfp_pair_vec_t      hiz_nxt;
  logic                          sd_n_nxt;
  logic                          wr_en;
  logic                          rd_en;
  logic                          addr_ok;

  assign reset_n    = {pair_two_reset_n_i, pair_one_reset_n_i};
  assign reset_rise = reset_n & ~reset_prev_r;
  assign oc_pair    = {|oc_trip_i[7:4], |oc_trip_i[3:0]};  // RULE19
  assign undervoltage_guard = gate_drive_supply_uv_i | logic_supply_uv_i;

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Frozen clock means no write can land, so the access waits
  assign pready_o = clk_en_i;
  assign addr_ok  = (paddr_i == `ASFP_OFF_CTRL) ||
                    (paddr_i == `ASFP_OFF_STATUS) ||
                    (paddr_i == `ASFP_OFF_IRQ_STAT) ||
                    (paddr_i == `ASFP_OFF_IRQ_MASK) ||
                    (paddr_i == `ASFP_OFF_TRIP);
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign wr_en = psel_i & penable_i & pwrite_i & clk_en_i & addr_ok;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bridge_tied_mode_r     <= `ASFP_CTRL_BTL_RST;
      overcurrent_trip_set_r <= asfp_pkg::ASFP_SET_15K;
      irq_mask_r             <= `ASFP_MASK_RST;
    end else if (wr_en) begin
      if (paddr_i == `ASFP_OFF_CTRL) begin
        bridge_tied_mode_r     <= pwdata_i[`ASFP_CTRL_BTL_BIT];
        overcurrent_trip_set_r <= asfp_pkg::asfp_trip_set_t'(
          pwdata_i[`ASFP_CTRL_SET_HI:`ASFP_CTRL_SET_LO]);
      end
      if (paddr_i == `ASFP_OFF_IRQ_MASK) begin
        irq_mask_r <= pwdata_i[`ASFP_EVT_W-1:0];
      end
    end
  end

  // Read data captured in setup, held through the access phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
    end else if (clk_en_i && rd_en) begin
      prdata_o <= 32'h0;
      unique case (paddr_i)
        `ASFP_OFF_CTRL: begin
          prdata_o[`ASFP_CTRL_BTL_BIT] <= bridge_tied_mode_r;
          prdata_o[`ASFP_CTRL_SET_HI:`ASFP_CTRL_SET_LO] <=
            overcurrent_trip_set_r;
        end
        `ASFP_OFF_STATUS: begin
          prdata_o[9:0] <= {fault_shutdown_n_i, overtemp_warning_n_i,
                            pair_two_hiz_o, pair_one_hiz_o, por_done_r,
                            undervoltage_guard, overtemp_shutdown_latch_r,
                            overload_latch_r, overtemp_warn_i};
        end
        `ASFP_OFF_IRQ_STAT: prdata_o[`ASFP_EVT_W-1:0] <= irq_stat_r;
        `ASFP_OFF_IRQ_MASK: prdata_o[`ASFP_EVT_W-1:0] <= irq_mask_r;
        `ASFP_OFF_TRIP:     prdata_o[7:0] <= trip_level_o;
        default:            prdata_o <= 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Trip level selection
  // --------------------------------------------------------------------
  // Codes past the table fall to the lowest, safest trip current
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      trip_level_o <= `ASFP_TRIP_15K;
    end else if (clk_en_i) begin
      unique case (overcurrent_trip_set_r)                  // RULE4
        asfp_pkg::ASFP_SET_15K: trip_level_o <= `ASFP_TRIP_15K;
        asfp_pkg::ASFP_SET_22K: trip_level_o <= `ASFP_TRIP_22K;
        asfp_pkg::ASFP_SET_27K: trip_level_o <= `ASFP_TRIP_27K;
        asfp_pkg::ASFP_SET_39K: trip_level_o <= `ASFP_TRIP_39K;
        asfp_pkg::ASFP_SET_47K: trip_level_o <= `ASFP_TRIP_47K;
        default:                trip_level_o <= `ASFP_TRIP_69K;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Power-on reset and edge history
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      por_done_r   <= 1'h0;
      // Idle level of the reset pins, so release shows no false edge
      reset_prev_r <= 2'h3;
      uv_prev_r    <= 1'h0;
      warn_prev_r  <= 1'h0;
    end else if (clk_en_i) begin
      if (supply_at_level_i) begin
        por_done_r <= 1'h1;                                 // RULE8
      end
      reset_prev_r <= reset_n;
      uv_prev_r    <= undervoltage_guard;
      warn_prev_r  <= overtemp_warn_i;
    end
  end

  // --------------------------------------------------------------------
  // Overload detection per pair
  // --------------------------------------------------------------------
  // A short burst only limits; the latch needs an unbroken trip run
  for (genvar p = 0; p < 2; p++) begin : g_pair
    assign ol_set[p] = oc_pair[p] && (ol_cnt_r[p] == OL_LAST);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        ol_cnt_r[p]         <= '0;
        overload_latch_r[p] <= 1'h0;
      end else if (clk_en_i) begin
        if (!por_done_r) begin
          ol_cnt_r[p]         <= '0;                        // RULE8
          overload_latch_r[p] <= 1'h0;
        end else begin
          if (!oc_pair[p] || overload_latch_r[p]) begin
            ol_cnt_r[p] <= '0;
          end else if (!ol_set[p]) begin
            ol_cnt_r[p] <= ol_cnt_r[p] + 1'h1;              // RULE3
          end
          if (ol_set[p]) begin
            overload_latch_r[p] <= 1'h1;                    // RULE2
          end else if (|reset_rise) begin
            overload_latch_r[p] <= 1'h0;                    // RULE15
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Thermal shutdown latch
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overtemp_shutdown_latch_r <= 1'h0;
    end else if (clk_en_i) begin
      if (overtemp_shut_i) begin
        overtemp_shutdown_latch_r <= 1'h1;                  // RULE6
      end else if (reset_n == 2'h0) begin
        overtemp_shutdown_latch_r <= 1'h0;                  // RULE7
      end
    end
  end

  // --------------------------------------------------------------------
  // Output stage control and flags
  // --------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      hiz_nxt[p] = !por_done_r || undervoltage_guard ||     // RULE9
                   overtemp_shutdown_latch_r ||             // RULE6
                   overload_latch_r[p] || !reset_n[p];      // RULE11
    end
    if (reset_n != 2'h3) begin
      sd_n_nxt = 1'h1;                                      // RULE14
    end else begin
      sd_n_nxt = !(overtemp_shutdown_latch_r || undervoltage_guard ||
                   (|overload_latch_r));                    // RULE16
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pair_one_hiz_o       <= 1'h1;
      pair_two_hiz_o       <= 1'h1;
      current_limit_o      <= 2'h0;
      pulldown_en_o        <= 2'h0;
      fault_shutdown_n_o   <= 1'h1;
      overtemp_warning_n_o <= 1'h1;
    end else if (clk_en_i) begin
      pair_one_hiz_o  <= hiz_nxt[0];                        // RULE10
      pair_two_hiz_o  <= hiz_nxt[1];
      current_limit_o <= oc_pair & ~hiz_nxt;                // RULE1
      // Single-ended keeps pulldowns off; bootstrap is the modulator's job
      pulldown_en_o   <= bridge_tied_mode_r ? ~reset_n  // RULE12
                                            : 2'h0;     // RULE13
      fault_shutdown_n_o   <= sd_n_nxt;
      overtemp_warning_n_o <= !overtemp_warn_i;             // RULE5
    end
  end

  // Open drain: drive only the low level
  assign fault_shutdown_n_oe_o   = !fault_shutdown_n_o;
  assign overtemp_warning_n_oe_o = !overtemp_warning_n_o;   // RULE18

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  assign evt[`ASFP_EVT_OL_ONE] = ol_set[0] && por_done_r;
  assign evt[`ASFP_EVT_OL_TWO] = ol_set[1] && por_done_r;
  assign evt[`ASFP_EVT_THERM]  = overtemp_shut_i && !overtemp_shutdown_latch_r;
  assign evt[`ASFP_EVT_UV]     = undervoltage_guard && !uv_prev_r;
  assign evt[`ASFP_EVT_WARN]   = overtemp_warn_i && !warn_prev_r;

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_r <= '0;
    end else if (clk_en_i) begin
      if (wr_en && paddr_i == `ASFP_OFF_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata_i[`ASFP_EVT_W-1:0]) | evt;
      end else begin
        irq_stat_r <= irq_stat_r | evt;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'h0;
    end else if (clk_en_i) begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Ticks only on enabled edges, matching when state may move
  default clocking cb @(posedge core_clk_i iff clk_en_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_trip_one_at_last;
    oc_pair[0] && ol_cnt_r[0] == OL_LAST && por_done_r && !overload_latch_r[0];
  endsequence
  sequence s_one_latched_off;
    overload_latch_r[0] ##1 pair_one_hiz_o;
  endsequence

  AST_OL_SHUT: assert property (s_trip_one_at_last |=> s_one_latched_off) // RULE2
    else $error("Persistent overcurrent did not latch pair one off");
  AST_OL_INDEP: assert property (                                      // RULE3
    s_trip_one_at_last and (!overload_latch_r[1] && !oc_pair[1])
    |=> !overload_latch_r[1])
    else $error("Pair one overload leaked into pair two");
  AST_LIMIT: assert property (                                         // RULE1
    oc_pair[0] && !hiz_nxt[0] |=> current_limit_o[0] && !pair_one_hiz_o)
    else $error("Overcurrent did not limit pair one");
  AST_UV_OFF: assert property (                                        // RULE9
    undervoltage_guard |=> pair_one_hiz_o && pair_two_hiz_o)
    else $error("Undervoltage left an output active");
  AST_UV_RESUME: assert property (                                     // RULE10
    $fell(undervoltage_guard) && por_done_r && reset_n == 2'h3 &&
    !overtemp_shutdown_latch_r && overload_latch_r == 2'h0 |=>
    !pair_one_hiz_o && !pair_two_hiz_o)
    else $error("Outputs did not resume after undervoltage");
  AST_RST_OFF: assert property (                                       // RULE11
    !pair_one_reset_n_i |=> pair_one_hiz_o && pulldown_en_o[0] ==
    $past(bridge_tied_mode_r))
    else $error("Pair one reset did not turn the pair off");
  AST_SE_NO_PD: assert property (                                      // RULE13
    !bridge_tied_mode_r |=> pulldown_en_o == 2'h0)
    else $error("Pulldown enabled in single-ended mode");
  AST_SD_FORCE: assert property (                                      // RULE14
    reset_n != 2'h3 |=> fault_shutdown_n_o && !fault_shutdown_n_oe_o)
    else $error("Shutdown flag not forced high during reset");
  AST_THERM_HOLD: assert property (                                    // RULE7
    overtemp_shutdown_latch_r && reset_n != 2'h0 |=>
    overtemp_shutdown_latch_r)
    else $error("Thermal latch cleared without both resets");
  AST_OL_CLR: assert property (                                        // RULE15
    por_done_r && |reset_rise && !ol_set[0] |=> !overload_latch_r[0])
    else $error("Reset rising edge did not clear overload");
  AST_WARN: assert property (                                          // RULE5
    overtemp_warn_i && !overtemp_shut_i |=> !overtemp_warning_n_o
    ##0 overtemp_warning_n_oe_o)
    else $error("Warning flag not driven low");
  AST_WARN_REL: assert property (                                      // RULE18
    $fell(overtemp_warn_i) |=> overtemp_warning_n_o)
    else $error("Warning flag did not release");
  AST_THERM_OFF: assert property (  // RULE6
    overtemp_shut_i |=> overtemp_shutdown_latch_r ##1
    (pair_one_hiz_o && pair_two_hiz_o))
    else $error("Thermal shutdown left an output active");
  AST_BTL_PD: assert property (  // RULE12
    bridge_tied_mode_r && !pair_two_reset_n_i |=> pulldown_en_o[1])
    else $error("Pair two pulldown not enabled in reset");
  AST_SD_FAULT: assert property (  // RULE16
    reset_n == 2'h3 && undervoltage_guard |=> !fault_shutdown_n_o)
    else $error("Undervoltage not flagged on shutdown flag");

endmodule
`default_nettype wire

/* src/asfp_consts.svh */
// Constants for the amplifier stage fault protection block
`ifndef ASFP_CONSTS_SVH
`define ASFP_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASFP_ADDR_W        8
`define ASFP_OFF_CTRL      8'h00
`define ASFP_OFF_STATUS    8'h04
`define ASFP_OFF_IRQ_STAT  8'h08
`define ASFP_OFF_IRQ_MASK  8'h0C
`define ASFP_OFF_TRIP      8'h10

// ----------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------
`define ASFP_CTRL_BTL_BIT  0
`define ASFP_CTRL_SET_LO   4
`define ASFP_CTRL_SET_HI   6
`define ASFP_CTRL_BTL_RST  1'h1
`define ASFP_SET_RST       3'h0
`define ASFP_MASK_RST      5'h00

// ----------------------------------------------------------------------
// Event bits in status and mask registers
// ----------------------------------------------------------------------
`define ASFP_EVT_W         5
`define ASFP_EVT_OL_ONE    0
`define ASFP_EVT_OL_TWO    1
`define ASFP_EVT_THERM     2
`define ASFP_EVT_UV        3
`define ASFP_EVT_WARN      4

// ----------------------------------------------------------------------
// Trip levels in tenths of an ampere, one per resistor setting
// ----------------------------------------------------------------------
`define ASFP_TRIP_15K      8'h6C
`define ASFP_TRIP_22K      8'h5E
`define ASFP_TRIP_27K      8'h56
`define ASFP_TRIP_39K      8'h40
`define ASFP_TRIP_47K      8'h3C
`define ASFP_TRIP_69K      8'h2F

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASFP_CLK_PERIOD_NS 10
`define ASFP_OL_TIME_NS    10000
`define ASFP_OL_CYCLES     (`ASFP_OL_TIME_NS / `ASFP_CLK_PERIOD_NS)
`define ASFP_OL_CNT_W      10

`endif

/* src/asfp_pkg.sv */
// Types for the amplifier stage fault protection block
package asfp_pkg;

  typedef logic [1:0] asfp_pair_vec_t;

  typedef enum logic [2:0] {
    ASFP_SET_15K = 3'h0,
    ASFP_SET_22K = 3'h1,
    ASFP_SET_27K = 3'h2,
    ASFP_SET_39K = 3'h3,
    ASFP_SET_47K = 3'h4,
    ASFP_SET_69K = 3'h5
  } asfp_trip_set_t;

endpackage

/* tb/asfp_ctrl_model.sv */
// Controller model: drives the pair resets, pulls up the flag pins
`timescale 1ns/1ps
`default_nettype none
module asfp_ctrl_model #(
  parameter int RECOVER_CYC = 200
) (
  input  wire logic clk_i,
  input  wire logic sd_oe_i,
  input  wire logic warn_oe_i,
  output var logic  pair_one_reset_n_o,
  output var logic  pair_two_reset_n_o,
  output wire logic sd_pin_o,
  output wire logic warn_pin_o
);
  // ------------------------------------------------------------------
  // Open-drain flags
  // ------------------------------------------------------------------
  // Pull-up wins whenever the device lets go of the pin
  assign sd_pin_o   = sd_oe_i ? 1'b0 : 1'b1;
  assign warn_pin_o = warn_oe_i ? 1'b0 : 1'b1;
  initial begin
    pair_one_reset_n_o = 1'b1;
    pair_two_reset_n_o = 1'b1;
  end
  // Bit 0 pair one, bit 1 pair two; both low together clears thermal
  task automatic set_rst(input logic [1:0] v);
    @(posedge clk_i);
    pair_one_reset_n_o <= v[0];
    pair_two_reset_n_o <= v[1];
  endtask
  // Recovery wait shortened from a second to keep the run short
  task automatic recover();
    repeat (RECOVER_CYC) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/asfp_top_tb_top.sv */
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
`default_nettype none
`include "asfp_consts.svh"
module asfp_top_tb_top;
  logic        core_clk_i, sys_rst_i, clk_en_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i, oc_trip_i, trip_level_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, err, irq_o, sd_pin, warn_pin;
  logic        pair_one_reset_n_i, pair_two_reset_n_i, supply_at_level_i;
  logic        overtemp_warn_i, overtemp_shut_i;
  logic        gate_drive_supply_uv_i, logic_supply_uv_i;
  logic        fault_shutdown_n_o, fault_shutdown_n_oe_o;
  logic        overtemp_warning_n_o, overtemp_warning_n_oe_o;
  logic        pair_one_hiz_o, pair_two_hiz_o;
  logic [1:0]  current_limit_o, pulldown_en_o;
  int          n_fail, compares;
  logic [7:0]  trip_tab [8] = '{`ASFP_TRIP_15K, `ASFP_TRIP_22K,
    `ASFP_TRIP_27K, `ASFP_TRIP_39K, `ASFP_TRIP_47K, `ASFP_TRIP_69K,
    `ASFP_TRIP_69K, `ASFP_TRIP_69K};

  asfp_top DUT (.core_clk_i, .sys_rst_i, .clk_en_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .pair_one_reset_n_i, .pair_two_reset_n_i, .oc_trip_i, .overtemp_warn_i,
    .overtemp_shut_i, .gate_drive_supply_uv_i, .logic_supply_uv_i,
    .supply_at_level_i, .fault_shutdown_n_i(sd_pin), .fault_shutdown_n_o,
    .fault_shutdown_n_oe_o, .overtemp_warning_n_i(warn_pin),
    .overtemp_warning_n_o, .overtemp_warning_n_oe_o, .pair_one_hiz_o,
    .pair_two_hiz_o, .current_limit_o, .pulldown_en_o, .trip_level_o, .irq_o);

  asfp_ctrl_model #(.RECOVER_CYC(200)) ctrl (.clk_i(core_clk_i),
    .sd_oe_i(fault_shutdown_n_oe_o), .warn_oe_i(overtemp_warning_n_oe_o),
    .pair_one_reset_n_o(pair_one_reset_n_i),
    .pair_two_reset_n_o(pair_two_reset_n_i),
    .sd_pin_o(sd_pin), .warn_pin_o(warn_pin));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Lands one step after the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {sys_rst_i, clk_en_i} = 2'b11;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {oc_trip_i, overtemp_warn_i, overtemp_shut_i} = '0;
    {gate_drive_supply_uv_i, logic_supply_uv_i, supply_at_level_i} = '0;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    tick(2);
    chk({pair_one_hiz_o, pair_two_hiz_o}, 2'b11, "off before supply");
    apb(1'b0, `ASFP_OFF_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, `ASFP_OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'h0, "mask reset");
    @(posedge core_clk_i);
    supply_at_level_i <= 1'b1;
    tick(3);
    chk({pair_one_hiz_o, pair_two_hiz_o}, 2'b00, "supply good");
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `ASFP_OFF_CTRL, {25'h0, i[2:0], 4'h1});
      tick(2);
      chk(trip_level_o, trip_tab[i], "trip level");
      apb(1'b0, `ASFP_OFF_TRIP, 32'h0);
      chk(rd, {24'h0, trip_tab[i]}, "trip reg");
    end
    @(posedge core_clk_i);
    oc_trip_i <= 8'h01;
    tick(990);
    chk({current_limit_o, pair_one_hiz_o, sd_pin}, 4'h5, "limit");
    tick(15);
    chk({pair_one_hiz_o, pair_two_hiz_o}, 2'b10, "ol one");
    @(posedge core_clk_i);
    oc_trip_i <= 8'h20;
    tick(1005);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h6, "overload");
    chk(irq_o, 1'b0, "masked irq");
    @(posedge core_clk_i);
    oc_trip_i <= 8'h00;
    apb(1'b1, `ASFP_OFF_IRQ_MASK, 32'h2);
    tick(2);
    chk(irq_o, 1'b1, "irq raised");
    ctrl.recover();
    ctrl.set_rst(2'b01);
    tick(2);
    chk({sd_pin, pulldown_en_o, pair_two_hiz_o}, 4'hD, "reset low");
    ctrl.set_rst(2'b11);
    tick(3);
    chk({pair_two_hiz_o, sd_pin}, 2'b01, "resumed");
    apb(1'b1, `ASFP_OFF_IRQ_STAT, 32'h2);
    tick(2);
    chk(irq_o, 1'b0, "irq cleared");
    @(posedge core_clk_i);
    overtemp_warn_i <= 1'b1;
    tick(3);
    chk({warn_pin, sd_pin, pair_one_hiz_o}, 3'b010, "warning");
    @(posedge core_clk_i);
    overtemp_warn_i <= 1'b0;
    tick(3);
    chk(warn_pin, 1'b1, "warning gone");
    @(posedge core_clk_i);
    overtemp_shut_i <= 1'b1;
    tick(3);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h6, "thermal");
    @(posedge core_clk_i);
    overtemp_shut_i <= 1'b0;
    ctrl.set_rst(2'b10);
    ctrl.set_rst(2'b11);
    tick(3);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h6, "one reset");
    ctrl.set_rst(2'b00);
    ctrl.set_rst(2'b11);
    tick(3);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h1, "both reset");
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk_i);
      {gate_drive_supply_uv_i, logic_supply_uv_i} <= 2'b01 << k;
      tick(2);
      chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h6, "uv");
      @(posedge core_clk_i);
      {gate_drive_supply_uv_i, logic_supply_uv_i} <= 2'b00;
      tick(2);
      chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h1, "uv gone");
    end
    apb(1'b1, `ASFP_OFF_CTRL, 32'h0);
    ctrl.set_rst(2'b10);
    tick(2);
    chk({pulldown_en_o, pair_one_hiz_o, pair_two_hiz_o}, 4'h2, "se reset");
    ctrl.set_rst(2'b11);
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    overtemp_warn_i <= 1'b1;
    tick(4);
    chk({warn_pin, pready_o}, 2'b10, "frozen");
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    tick(2);
    chk(warn_pin, 1'b0, "thawed");
    @(posedge core_clk_i);
    {sys_rst_i, supply_at_level_i, overtemp_warn_i} <= 3'b100;
    tick(2);
    chk({pair_one_hiz_o, pair_two_hiz_o, warn_pin}, 3'h7, "in reset");
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    tick(2);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h7, "no supply");
    apb(1'b0, `ASFP_OFF_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl after reset");
    supply_at_level_i <= 1'b1;
    tick(3);
    chk({pair_one_hiz_o, pair_two_hiz_o, sd_pin}, 3'h1, "supply");
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    tick(2);
    print_verdict();
  end
endmodule
`default_nettype wire
